// ### dwm_controller.sv
// memory controller end: link clock, enable and write masks
`timescale 1ns/100ps
`default_nettype none
module dwm_controller
  import dwm_pkg::*;
(
  // system clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // user request
  input  wire logic             req_valid,
  input  wire dwm_req_t         req_kind,
  input  wire logic [3:0]       req_addr,
  input  wire logic [DQ_W-1:0]  req_data,
  input  wire logic [1:0]       req_block,
  output logic                  req_ready,
  // link
  dwm_link_if.ctl               lnk
);
  typedef enum logic [2:0] {
    CS_RUN, CS_ACT, CS_DATA, CS_LOW, CS_WAKE, CS_WAIT
  } dwm_cstate_t;

  dwm_cstate_t         st_r, st_nxt;
  logic [3:0]          div_r, div_nxt;
  logic                lclk_r, lclk_nxt;
  logic                cke_r, cke_nxt;
  logic [3:0]          cmd_r, cmd_nxt;
  logic [3:0]          addr_r, addr_nxt;
  logic [DQ_W-1:0]     dq_r, dq_nxt;
  logic                oe_r, oe_nxt;
  logic [1:0]          msk_r, msk_nxt;
  logic [3:0]          cnt_r, cnt_nxt;
  dwm_req_t            kind_r, kind_nxt;
  logic                rdy_r, rdy_nxt;
  logic [1:0]          blk_r, blk_nxt;
  logic                fall;
  logic                pre_fall;

  // link edges change on the falling half so the device sees stable pins
  assign fall = (div_r == DIV_LAST) && lclk_r;
  // ready stands only on the edge that lowers the link clock, so a request
  // taken there is the one the fall branch sees; a kind that state does not act on is dropped
  assign pre_fall = (div_r == DIV_LAST - 4'h1) && lclk_r;

  always_comb
  begin
    div_nxt  = (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
    lclk_nxt = (div_r == DIV_LAST) ? !lclk_r : lclk_r;
    st_nxt   = st_r;
    cke_nxt  = cke_r;
    cmd_nxt  = cmd_r;
    addr_nxt = addr_r;
    dq_nxt   = dq_r;
    oe_nxt   = oe_r;
    msk_nxt  = msk_r;
    cnt_nxt  = cnt_r;
    kind_nxt = kind_r;
    rdy_nxt  = pre_fall && (st_r == CS_RUN || st_r == CS_LOW);
    blk_nxt  = blk_r;
    if (fall)
    begin
      cmd_nxt = CMD_NOP;
      oe_nxt  = 1'b0;
      msk_nxt = 2'h3;
      case (st_r)
        CS_RUN:
        begin
          if (req_valid && rdy_r)
          begin
            kind_nxt = req_kind;
            addr_nxt = req_addr;
            // data and masks captured when taken, not read later
            dq_nxt   = req_data;
            blk_nxt  = req_block;
            if (req_kind == DWM_REQ_WRITE || req_kind == DWM_REQ_READ)
            begin
              cmd_nxt = CMD_ACTIVE;
              st_nxt  = CS_ACT;
            end
            else if (req_kind == DWM_REQ_PWRDN)
            begin
              cke_nxt = 1'b0;
              st_nxt  = CS_LOW;
            end
            else if (req_kind == DWM_REQ_SELF)
            begin
              cmd_nxt = CMD_SELF;                     // banks idle here
              cke_nxt = 1'b0;
              st_nxt  = CS_LOW;
            end
          end
        end
        CS_ACT:
        begin
          cmd_nxt = (kind_r == DWM_REQ_WRITE) ? CMD_WRITE : CMD_READ;
          msk_nxt = blk_r;
          st_nxt  = CS_DATA;
        end
        CS_DATA:
        begin
          // data and masks on the beat after the write; never stopped
          if (kind_r == DWM_REQ_WRITE)
            oe_nxt = 1'b1;
          else
            msk_nxt = 2'h0;
          if (kind_r == DWM_REQ_WRITE)
            msk_nxt = msk_r;
          cmd_nxt = CMD_PRE;
          st_nxt  = CS_RUN;
        end
        CS_LOW:
        begin
          // enable held low, nop only, until a wake request
          if (req_valid && rdy_r && req_kind == DWM_REQ_WAKE)
          begin
            cnt_nxt = 4'h0;
            st_nxt  = CS_WAKE;
          end
        end
        CS_WAKE:
        begin
          // clock has toggled at least one full cycle while low
          cke_nxt = 1'b1;
          st_nxt  = CS_WAIT;
        end
        CS_WAIT:
        begin
          // exit delay covers self refresh and its recovery
          if (cnt_r == SR_EXIT_LAST)
            st_nxt = CS_RUN;
          else
            cnt_nxt = cnt_r + 4'h1;
        end
        default:
          st_nxt = CS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r   <= CS_RUN;
      div_r  <= 4'h0;
      lclk_r <= 1'b0;
      cke_r  <= 1'b1;
      cmd_r  <= CMD_DESELECT;
      addr_r <= 4'h0;
      dq_r   <= 16'h0000;
      oe_r   <= 1'b0;
      msk_r  <= 2'h3;
      blk_r  <= 2'h3;
      cnt_r  <= 4'h0;
      kind_r <= DWM_REQ_NONE;
      rdy_r  <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      lclk_r <= lclk_nxt;
      cke_r  <= cke_nxt;
      cmd_r  <= cmd_nxt;
      addr_r <= addr_nxt;
      dq_r   <= dq_nxt;
      oe_r   <= oe_nxt;
      msk_r  <= msk_nxt;
      blk_r  <= blk_nxt;
      cnt_r  <= cnt_nxt;
      kind_r <= kind_nxt;
      rdy_r  <= rdy_nxt;
    end
  end

  assign lnk.link_clk              = lclk_r;
  assign lnk.clk_en                = cke_r;
  assign lnk.cmd                   = cmd_r;
  assign lnk.row_addr              = addr_r;
  assign lnk.dq_ctl                = dq_r;
  assign lnk.dq_ctl_oe             = oe_r;
  assign lnk.lower_byte_write_mask = msk_r[0];
  assign lnk.upper_byte_write_mask = msk_r[1];
  assign req_ready                 = rdy_r;
endmodule
`default_nettype wire

// ### dwm_pkg.sv
// shared constants and types for the write-mask / clock-enable link
package dwm_pkg;
  // data width fixed at the sixteen-bit organization, two byte lanes
  localparam int DQ_W           = 16;
  localparam int MASK_W         = 2;
  localparam int BYTE_W         = 8;
  localparam int BANK_ROW_W     = 4;
  localparam int ROW_W          = 16;
  // row cycle time after self refresh recovery, in ns, rounded up to link cycles
  localparam int ROW_CYCLE_NS   = 70;
  localparam int LINK_PERIOD_NS = 125;
  localparam int ROW_CYCLE_CYC  =
    (ROW_CYCLE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // self refresh exit delay the controller keeps, in link cycles
  localparam int SR_EXIT_CYC    = 10;
  // controller clock divider: half period in clk cycles
  localparam int LINK_HALF_DIV  = 6;
  localparam logic [3:0] DIV_LAST = 4'h5;
  localparam logic [3:0] SR_EXIT_LAST = 4'h9;
  localparam logic [3:0] ROW_CYC_LAST = 4'(ROW_CYCLE_CYC - 1);

  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESELECT = 4'h8;
  localparam logic [3:0] CMD_NOP      = 4'h7;
  localparam logic [3:0] CMD_ACTIVE   = 4'h3;
  localparam logic [3:0] CMD_READ     = 4'h5;
  localparam logic [3:0] CMD_WRITE    = 4'h4;
  localparam logic [3:0] CMD_BST      = 4'h6;
  localparam logic [3:0] CMD_PRE      = 4'h2;
  localparam logic [3:0] CMD_SELF     = 4'h1;

  typedef enum logic [2:0] {
    DWM_IDLE, DWM_ACTIVE, DWM_PWRDN, DWM_SELFREF, DWM_SR_RECOV
  } dwm_state_t;

  typedef enum logic [2:0] {
    DWM_REQ_NONE, DWM_REQ_WRITE, DWM_REQ_READ, DWM_REQ_PWRDN,
    DWM_REQ_SELF, DWM_REQ_WAKE
  } dwm_req_t;
endpackage

// ### dwm_link_if.sv
// link between memory controller and memory device
`timescale 1ns/100ps
`default_nettype none
interface dwm_link_if;
  logic        link_clk;     // controller-made link clock
  logic        clk_en;       // clock enable
  logic [3:0]  cmd;          // {cs_n, ras_n, cas_n, we_n}
  logic [3:0]  row_addr;     // row / column address
  logic [15:0] dq_ctl;       // write data from controller
  logic        dq_ctl_oe;
  logic [15:0] dq_dev;       // read data from device
  logic        dq_dev_oe;
  logic        lower_byte_write_mask;
  logic        upper_byte_write_mask;
  modport ctl (output link_clk, clk_en, cmd, row_addr, dq_ctl, dq_ctl_oe,
               lower_byte_write_mask, upper_byte_write_mask,
               input dq_dev, dq_dev_oe);
  modport dev (input link_clk, clk_en, cmd, row_addr, dq_ctl, dq_ctl_oe,
               lower_byte_write_mask, upper_byte_write_mask,
               output dq_dev, dq_dev_oe);
endinterface
`default_nettype wire

// ### dwm_device.sv
// memory device end: write masking and clock-enable power states
`timescale 1ns/100ps
`default_nettype none
module dwm_device
  import dwm_pkg::*;
(
  // link, on the link clock
  dwm_link_if.dev          lnk,
  // user side, status in the link clock domain
  output logic [2:0]       dev_state,
  output logic             write_seen,
  output logic [DQ_W-1:0]  last_stored
);
  logic [DQ_W-1:0]   mem_r [0:(1<<BANK_ROW_W)-1];
  dwm_state_t        state_r, state_nxt;
  logic              cke_prev_r;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [BANK_ROW_W-1:0] addr_r, addr_nxt;
  logic              rd_pend_r, rd_pend_nxt;
  logic              wr_pend_r, wr_pend_nxt;
  logic [DQ_W-1:0]   dq_r, dq_nxt;
  logic              oe_r, oe_nxt;
  logic              seen_r, seen_nxt;
  logic [DQ_W-1:0]   last_r, last_nxt;
  logic              cmd_ok;
  logic              is_nop;
  logic              upper_write_allowed;
  logic              lower_write_allowed;
  logic              upper_write_blocked;
  logic              lower_write_blocked;

  // merge one beat under the byte masks; each mask governs its own lane,
  // so a one-lane build has a single mask over lines 7:0 only and never writes the lines above them
  function automatic logic [DQ_W-1:0] merge_beat(
    input logic [DQ_W-1:0] old_v,
    input logic [DQ_W-1:0] new_v,
    input logic [MASK_W-1:0] blk);
    logic [DQ_W-1:0] r;
    r = old_v;
    for (int b = 0; b < MASK_W; b++)
    begin
      if (!blk[b])
        r[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
    end
    return r;
  endfunction

  // the device has no reset; the link clock only runs while driven
  assign cmd_ok = cke_prev_r;
  assign is_nop = lnk.cmd[3] || (lnk.cmd == CMD_NOP);
  // masks sampled with the same beat they qualify
  assign upper_write_blocked = lnk.upper_byte_write_mask;
  assign lower_write_blocked = lnk.lower_byte_write_mask;
  assign upper_write_allowed = !upper_write_blocked;
  assign lower_write_allowed = !lower_write_blocked;

  // next-state for power states, burst and data path
  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    addr_nxt    = addr_r;
    rd_pend_nxt = 1'b0;
    wr_pend_nxt = 1'b0;
    dq_nxt      = dq_r;
    oe_nxt      = 1'b0;
    seen_nxt    = seen_r;
    last_nxt    = last_r;
    case (state_r)
      DWM_IDLE, DWM_ACTIVE:
      begin
        if (cmd_ok && !lnk.clk_en)
        begin
          // self refresh only when the command rides the falling enable
          if (lnk.cmd == CMD_SELF && state_r == DWM_IDLE)
            state_nxt = DWM_SELFREF;
          else
            state_nxt = DWM_PWRDN;
        end
        else if (cmd_ok)
        begin
          if (lnk.cmd == CMD_ACTIVE)
            state_nxt = DWM_ACTIVE;
          else if (lnk.cmd == CMD_PRE)
            state_nxt = DWM_IDLE;
          else if (lnk.cmd == CMD_WRITE && state_r == DWM_ACTIVE)
          begin
            addr_nxt    = lnk.row_addr;
            wr_pend_nxt = 1'b1;
          end
          else if (lnk.cmd == CMD_READ && state_r == DWM_ACTIVE)
          begin
            addr_nxt    = lnk.row_addr;
            rd_pend_nxt = 1'b1;
          end
        end
        if (wr_pend_r)
        begin
          seen_nxt = 1'b1;                            // masks only here
          last_nxt = merge_beat(mem_r[addr_r], lnk.dq_ctl,
                                {upper_write_blocked, lower_write_blocked});
        end
        if (rd_pend_r)
        begin
          dq_nxt = mem_r[addr_r];                     // read never masked
          oe_nxt = 1'b1;
        end
      end
      DWM_PWRDN:
      begin
        // inputs other than enable and the exit nop are ignored; bus floats
        if (lnk.clk_en && is_nop)
          state_nxt = DWM_IDLE;
      end
      DWM_SELFREF:
      begin
        if (lnk.clk_en && is_nop)
        begin
          state_nxt = DWM_SR_RECOV;
          cnt_nxt   = 4'h0;
        end
      end
      DWM_SR_RECOV:
      begin
        // only nop allowed; counts row cycle time
        if (cnt_r == ROW_CYC_LAST)
          state_nxt = DWM_IDLE;
        else
          cnt_nxt = cnt_r + 4'h1;
      end
      default:
        state_nxt = DWM_IDLE;
    endcase
  end

  // registers on the link clock
  always_ff @(posedge lnk.link_clk)
  begin
    cke_prev_r <= lnk.clk_en;
    state_r    <= state_nxt;
    cnt_r      <= cnt_nxt;
    addr_r     <= addr_nxt;
    rd_pend_r  <= rd_pend_nxt;
    wr_pend_r  <= wr_pend_nxt;
    dq_r       <= dq_nxt;
    oe_r       <= oe_nxt;
    seen_r     <= seen_nxt;
    last_r     <= last_nxt;
    if (wr_pend_r && (state_r == DWM_IDLE || state_r == DWM_ACTIVE))
      mem_r[addr_r] <= last_nxt;
  end

  assign lnk.dq_dev    = dq_r;
  assign lnk.dq_dev_oe = oe_r;                        // floats in low power
  assign dev_state     = state_r;
  assign write_seen    = seen_r;
  assign last_stored   = last_r;
endmodule
`default_nettype wire

// ### dwm_link_sva.sv
// link checker: clock-enable, write-beat and read-beat timing on the link
`timescale 1ns/100ps
`default_nettype none
module dwm_link_sva
  import dwm_pkg::*;
(
  // link clock domain
  input wire logic       link_clk,
  input wire logic       arst_n,
  // link signals
  input wire logic       clk_en,
  input wire logic [3:0] cmd,
  input wire logic       dq_ctl_oe,
  input wire logic       dq_dev_oe
);
  logic       idle_cmd;
  logic       cke_q_r, cke_q_nxt;
  logic       sr_r, sr_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic [1:0] warm_r, warm_nxt;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!arst_n);

  // deselect (chip select high), no-operation or burst stop
  assign idle_cmd = cmd[3] || (cmd[3:1] == 3'b011);

  // self refresh tracking; warm_r hides the unknown history before reset
  always_comb
  begin
    cke_q_nxt = clk_en;
    warm_nxt  = (warm_r == 2'h3) ? warm_r : warm_r + 2'h1;
    sr_nxt    = sr_r;
    gap_nxt   = (gap_r != 4'h0) ? gap_r - 4'h1 : gap_r;
    if (cke_q_r && !clk_en && cmd == CMD_SELF)
      sr_nxt = 1'b1;
    else if (sr_r && clk_en)
    begin
      sr_nxt  = 1'b0;
      gap_nxt = SR_EXIT_LAST;
    end
  end

  // helper registers
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cke_q_r <= 1'b1;
      sr_r    <= 1'b0;
      gap_r   <= 4'h0;
      warm_r  <= 2'h0;
    end
    else
    begin
      cke_q_r <= cke_q_nxt;
      sr_r    <= sr_nxt;
      gap_r   <= gap_nxt;
      warm_r  <= warm_nxt;
    end
  end

  // transfer steps
  sequence s_write_cmd; cke_q_r && cmd == CMD_WRITE; endsequence
  sequence s_write_beat; dq_ctl_oe; endsequence
  sequence s_read_cmd; cke_q_r && cmd == CMD_READ; endsequence
  sequence s_read_beat; ##[1:2] dq_dev_oe; endsequence
  sequence s_sr_exit; warm_r == 2'h3 && $fell(sr_r); endsequence

  write_beat_a : assert property (s_write_cmd |=> s_write_beat)
    else $error("write beat did not follow write command");
  beat_cause_a : assert property (dq_ctl_oe |-> $past(cmd) == CMD_WRITE)
    else $error("write beat without preceding write command");
  no_write_stop_a : assert property
    (cmd == CMD_WRITE |=> (cmd != CMD_BST)[*2])
    else $error("burst stop during write burst");
  read_beat_a : assert property (s_read_cmd |-> s_read_beat)
    else $error("read data not driven after read command");
  pd_quiet_a : assert property
    (!clk_en && !$past(clk_en) |-> idle_cmd)
    else $error("command issued while clock enable low");
  pd_float_a : assert property
    (!clk_en && !cke_q_r |-> !dq_dev_oe && !dq_ctl_oe)
    else $error("data bus driven in low power state");
  exit_nop_a : assert property ($rose(clk_en) |-> idle_cmd)
    else $error("low power exit without deselect or nop");
  cke_toggle_a : assert property
    (warm_r == 2'h3 && $rose(clk_en) |-> !$past(clk_en, 2))
    else $error("clock enable rose without a full low cycle");
  sr_quiet_a : assert property (gap_r != 4'h0 |-> idle_cmd)
    else $error("command inside self refresh exit delay");
  recov_cke_a : assert property (s_sr_exit |-> clk_en[*8])
    else $error("clock enable dropped in self refresh recovery");
endmodule
`default_nettype wire

// ### tb_ddr_write_mask_and_clock_gate.sv
// bench: controller and device joined over the link, user side driven
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_ddr_write_mask_and_clock_gate
  import dwm_pkg::*;
;
  logic            clk;
  logic            arst_n;
  logic            req_valid;
  dwm_req_t        req_kind;
  logic [3:0]      req_addr;
  logic [DQ_W-1:0] req_data;
  logic [1:0]      req_block;
  logic            req_ready;
  logic [2:0]      dev_state;
  logic            write_seen;
  logic [DQ_W-1:0] last_stored;
  logic [DQ_W-1:0] rd_word;
  logic [DQ_W-1:0] exp_word;
  int              n_mismatch;
  int              tests_run;

  dwm_link_if dwm_link_if_inst ();

  dwm_controller dwm_controller_inst (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
    .req_data(req_data), .req_block(req_block), .req_ready(req_ready),
    .lnk(dwm_link_if_inst));
  dwm_device dwm_device_inst (.lnk(dwm_link_if_inst), .dev_state(dev_state),
    .write_seen(write_seen), .last_stored(last_stored));
  dwm_link_sva dwm_link_sva_inst (.link_clk(dwm_link_if_inst.link_clk),
    .arst_n(arst_n), .clk_en(dwm_link_if_inst.clk_en),
    .cmd(dwm_link_if_inst.cmd), .dq_ctl_oe(dwm_link_if_inst.dq_ctl_oe),
    .dq_dev_oe(dwm_link_if_inst.dq_dev_oe));

  // 100 MHz system clock
  always #5 clk = ~clk;

  // read beats are caught off the link, the controller returns no data
  always @(posedge dwm_link_if_inst.link_clk)
    if (dwm_link_if_inst.dq_dev_oe === 1'b1)
      rd_word = dwm_link_if_inst.dq_dev;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bounded wait for ready sampled high at a clock edge
  task automatic wait_ready();
    int i;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge clk);
      if (req_ready === 1'b1)
        break;
    end
    `CHK(req_ready, 1'b1)
    if (req_ready !== 1'b1)
      final_report();
  endtask

  // one request held until taken, then run to the end of its sequence
  task automatic send(input dwm_req_t k, input logic [3:0] a,
                      input logic [DQ_W-1:0] d, input logic [1:0] b);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_addr  <= a;
    req_data  <= d;
    req_block <= b;
    wait_ready();
    req_valid <= 1'b0;
    @(posedge clk);
    wait_ready();
  endtask

  // read with both masks high: read data must come back whole
  task automatic read_chk(input logic [3:0] a, input logic [DQ_W-1:0] e);
    rd_word = ~e;
    send(DWM_REQ_READ, a, 16'h0000, 2'h3);
    // the read beat lands half a link cycle after ready returns
    repeat (12) @(posedge clk);
    `CHK(rd_word, e)
  endtask

  task automatic wait_state(input logic [2:0] st);
    int i;
    for (i = 0; i < 400 && dev_state !== st; i++)
      @(posedge clk);
    `CHK(dev_state, st)
    if (dev_state !== st)
      final_report();
  endtask

  initial
  begin
    clk        = 1'b0;
    arst_n     = 1'b0;
    req_valid  = 1'b0;
    req_kind   = DWM_REQ_NONE;
    req_addr   = 4'h0;
    req_data   = 16'h0000;
    req_block  = 2'h0;
    rd_word    = 16'h0000;
    exp_word   = 16'h0000;
    n_mismatch = 0;
    tests_run  = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    // first write only settles the device, which has no reset
    send(DWM_REQ_WRITE, 4'h0, 16'h0000, 2'h0);
    for (int b = 0; b < 4; b++)
    begin
      send(DWM_REQ_WRITE, 4'h3, 16'h1234, 2'h0);
      send(DWM_REQ_WRITE, 4'h3, 16'hcafe, 2'(b));
      exp_word = {b[1] ? 8'h12 : 8'hca, b[0] ? 8'h34 : 8'hfe};
      `CHK(last_stored, exp_word)
      read_chk(4'h3, exp_word);
    end
    `CHK(write_seen, 1'b1)
    $display("mask test done");
    send(DWM_REQ_PWRDN, 4'h0, 16'h0000, 2'h0);
    wait_state(DWM_PWRDN);
    `CHK(dwm_link_if_inst.dq_dev_oe, 1'b0)
    repeat (50) @(posedge clk);
    send(DWM_REQ_WAKE, 4'h0, 16'h0000, 2'h0);
    wait_state(DWM_IDLE);
    read_chk(4'h3, exp_word);
    $display("power-down test done");
    send(DWM_REQ_SELF, 4'h0, 16'h0000, 2'h0);
    wait_state(DWM_SELFREF);
    repeat (50) @(posedge clk);
    send(DWM_REQ_WAKE, 4'h0, 16'h0000, 2'h0);
    wait_state(DWM_IDLE);
    send(DWM_REQ_WRITE, 4'h3, 16'h5aa5, 2'h2);
    read_chk(4'h3, 16'h12a5);
    $display("self-refresh test done");
    final_report();
  end
endmodule
`default_nettype wire
